// file: src/pmt_pkg.sv
// Package with register map, field layout and reset values of the period match timer.
package pmt_pkg;

  // ****************************************************************
  // Bus and register geometry
  // ****************************************************************
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // Register indices; the byte address is four times the index.
  localparam logic [9:0] IDX_FLAG = 10'h00C;
  localparam logic [9:0] IDX_MASK = 10'h08C;
  localparam logic [9:0] IDX_COUNT = 10'h011;
  localparam logic [9:0] IDX_CTRL = 10'h012;
  localparam logic [9:0] IDX_PERIOD = 10'h092;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int unsigned PRE_LSB = 0;
  localparam int unsigned PRE_W = 2;
  localparam int unsigned RUN_BIT = 2;
  localparam int unsigned POST_LSB = 3;
  localparam int unsigned POST_W = 4;
  localparam int unsigned CTRL_W = 7;

  // Flag and mask layout: the match flag sits in bit 1.
  localparam int unsigned FLAG_BIT = 1;

  // Prescaler limits (ratio minus one) for 1:1, 1:4 and 1:16.
  localparam logic [3:0] PRE_LIM_1 = 4'h0;
  localparam logic [3:0] PRE_LIM_4 = 4'h3;
  localparam logic [3:0] PRE_LIM_16 = 4'hF;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'hFF;
  localparam logic [7:0] FLAG_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;

endpackage : pmt_pkg

// file: src/pmt_scaler.sv
// Event divider counter with synchronous clear and selectable terminal count.
module pmt_scaler #(
  parameter int unsigned WIDTH = 4
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Control.
  input wire logic clr,
  input wire logic inc,
  input wire logic [WIDTH-1:0] limit,
  // Results.
  output logic tick,
  output logic [WIDTH-1:0] cnt
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } pmt_scaler_state_t;

  pmt_scaler_state_t state_reg;
  pmt_scaler_state_t state_next;

  // Refuse a width outside the range 1 to 16.
  if (WIDTH < 1 || WIDTH > 16)
  begin : g_width_check
    $error("pmt_scaler: WIDTH out of range");
  end

  // A clear beats an event in the same cycle, so no tick leaks out of it.
  assign tick = inc && !clr && (state_reg.cnt == limit);
  assign cnt = state_reg.cnt;

  // Count events and wrap at the terminal count.
  always_comb
  begin
    state_next = state_reg;
    if (clr)
    begin
      state_next.cnt = '0;
    end
    else if (inc)
    begin
      if (state_reg.cnt >= limit)
      begin
        state_next.cnt = '0;
      end
      else
      begin
        state_next.cnt = state_reg.cnt + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  // Register the state.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

endmodule : pmt_scaler

// file: src/pmt_timer.sv
// Period match timer with prescaler, postscaler, APB registers and interrupt.
//
// Function
// - Count register clocked through 1/4/16 prescaler.
// - Postscaler ratio is field value plus one.
// - Postscaler terminal count sets match flag.
// - Count or control write, reset clear scalers.
// - Control write leaves count value unchanged.
// - Count register read/write, reset to zero.
// - Run bit enables counting; clear stops it.
// - Match signal drives PWM time base.
// - Pre-postscaler match routed to serial port.
// - Count wraps to zero after equalling period.
// - Period register read/write, reset to FFh.
//
// The implementer's own choice: the APB interface to the registers.
module pmt_timer (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pmt_pkg::ADDR_W-1:0] paddr,
  input wire logic [pmt_pkg::DATA_W-1:0] pwdata,
  output logic [pmt_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt.
  output logic irq,
  // Match outputs to neighbouring units.
  output logic pwm_time_base,
  output logic ssp_shift_source
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [pmt_pkg::CTRL_W-1:0] timer_control;
    logic [7:0] count_register;
    logic [7:0] period_register;
    logic [7:0] flag;
    logic [7:0] mask;
    logic pready;
    logic pslverr;
    logic [7:0] prdata;
    logic irq;
    logic match_out;
    logic ssp_out;
  } pmt_state_t;

  pmt_state_t state_reg;
  pmt_state_t state_next;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic access;
  logic finish;
  logic [9:0] index;
  logic hit_flag;
  logic hit_mask;
  logic hit_count;
  logic hit_ctrl;
  logic hit_period;
  logic mapped;
  logic wr_count;
  logic wr_ctrl;
  logic [7:0] wbyte;

  // The access phase lasts two cycles; the second one completes it.
  assign access = psel && penable;
  assign finish = access && state_reg.pready;
  assign index = paddr[pmt_pkg::ADDR_W-1:2];
  assign hit_flag = (index == pmt_pkg::IDX_FLAG);
  assign hit_mask = (index == pmt_pkg::IDX_MASK);
  assign hit_count = (index == pmt_pkg::IDX_COUNT);
  assign hit_ctrl = (index == pmt_pkg::IDX_CTRL);
  assign hit_period = (index == pmt_pkg::IDX_PERIOD);
  assign mapped = hit_flag || hit_mask || hit_count || hit_ctrl || hit_period;
  assign wr_count = finish && pwrite && hit_count;
  assign wr_ctrl = finish && pwrite && hit_ctrl;
  assign wbyte = pwdata[7:0];

  // ****************************************************************
  // Control fields and scalers
  // ****************************************************************
  logic [pmt_pkg::PRE_W-1:0] pre_sel;
  logic [pmt_pkg::POST_W-1:0] post_sel;
  logic run;
  logic [3:0] pre_limit;
  logic scaler_clr;
  logic pre_tick;
  logic [3:0] pre_cnt;
  logic match;
  logic post_tick;
  logic [3:0] post_cnt;

  assign pre_sel = state_reg.timer_control[pmt_pkg::PRE_LSB +: pmt_pkg::PRE_W];
  assign post_sel = state_reg.timer_control[pmt_pkg::POST_LSB +: pmt_pkg::POST_W];
  assign run = state_reg.timer_control[pmt_pkg::RUN_BIT];

  // Decode the input prescale select; either code with the upper bit set is 1:16.
  always_comb
  begin
    case (pre_sel)
      2'h0: pre_limit = pmt_pkg::PRE_LIM_1;
      2'h1: pre_limit = pmt_pkg::PRE_LIM_4;
      default: pre_limit = pmt_pkg::PRE_LIM_16;
    endcase
  end

  // Both scalers clear on a write to the count or the control register.
  assign scaler_clr = wr_count || wr_ctrl;

  // Input prescaler: the instruction clock is pclk, gated by the run bit.
  pmt_scaler #(
    .WIDTH(4)
  ) u_prescale (
    .pclk(pclk),
    .presetn(presetn),
    .clr(scaler_clr),
    .inc(run),
    .limit(pre_limit),
    .tick(pre_tick),
    .cnt(pre_cnt)
  );

  // A match event is an increment while the count equals the period.
  assign match = pre_tick && !wr_count && (state_reg.count_register == state_reg.period_register);

  // Output postscaler: ratio equals the field value plus one.
  pmt_scaler #(
    .WIDTH(pmt_pkg::POST_W)
  ) u_postscale (
    .pclk(pclk),
    .presetn(presetn),
    .clr(scaler_clr),
    .inc(match),
    .limit(post_sel),
    .tick(post_tick),
    .cnt(post_cnt)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    state_next = state_reg;

    // Bus answer: pready rises in the second access cycle.
    state_next.pready = access && !state_reg.pready;
    state_next.pslverr = access && !state_reg.pready && !mapped;
    state_next.prdata = 8'h00;
    if (access && !state_reg.pready && !pwrite)
    begin
      if (hit_flag)
      begin
        state_next.prdata = state_reg.flag;
      end
      else if (hit_mask)
      begin
        state_next.prdata = state_reg.mask;
      end
      else if (hit_count)
      begin
        state_next.prdata = state_reg.count_register;
      end
      else if (hit_ctrl)
      begin
        state_next.prdata = {1'b0, state_reg.timer_control};
      end
      else if (hit_period)
      begin
        state_next.prdata = state_reg.period_register;
      end
      else
      begin
        state_next.prdata = 8'h00;
      end
    end

    // Counter: a software write wins over an increment in the same cycle.
    if (wr_count)
    begin
      state_next.count_register = wbyte;
    end
    else if (match)
    begin
      state_next.count_register = 8'h00;
    end
    else if (pre_tick)
    begin
      state_next.count_register = state_reg.count_register + 8'h01;
    end

    // Control write changes only the fields; the count is left alone.
    if (wr_ctrl)
    begin
      state_next.timer_control = wbyte[pmt_pkg::CTRL_W-1:0];
    end

    // Period and mask registers.
    if (finish && pwrite && hit_period)
    begin
      state_next.period_register = wbyte;
    end
    if (finish && pwrite && hit_mask)
    begin
      state_next.mask = wbyte;
    end

    // Sticky flag: writing one clears, a new event in the same cycle wins.
    if (finish && pwrite && hit_flag)
    begin
      state_next.flag = state_reg.flag & ~wbyte;
    end
    if (post_tick)
    begin
      state_next.flag[pmt_pkg::FLAG_BIT] = 1'b1;
    end

    // Interrupt level and match outputs.
    state_next.irq = |(state_next.flag & state_reg.mask);
    state_next.match_out = match;
    state_next.ssp_out = match;
  end

  // Register the whole state; every kind of reset lands here.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg.timer_control <= pmt_pkg::CTRL_RST;
      state_reg.count_register <= pmt_pkg::COUNT_RST;
      state_reg.period_register <= pmt_pkg::PERIOD_RST;
      state_reg.flag <= pmt_pkg::FLAG_RST;
      state_reg.mask <= pmt_pkg::MASK_RST;
      state_reg.pready <= 1'b0;
      state_reg.pslverr <= 1'b0;
      state_reg.prdata <= 8'h00;
      state_reg.irq <= 1'b0;
      state_reg.match_out <= 1'b0;
      state_reg.ssp_out <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata = {24'h00_0000, state_reg.prdata};
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign irq = state_reg.irq;
  assign pwm_time_base = state_reg.match_out;
  assign ssp_shift_source = state_reg.ssp_out;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // The bus answers in the second access cycle.
  bus_answer_a: assert property ((psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready)
    else $error("pready not in second access cycle");

  // A running timer with 1:1 prescale ticks every cycle.
  pre_one_a: assert property ((run && pre_sel == 2'h0 && !scaler_clr) |-> pre_tick)
    else $error("1:1 prescale missed a tick");

  // A 1:4 prescale ticks in the fourth steady running cycle counted from a zero prescaler count.
  pre_four_a: assert property ((run && pre_sel == 2'h1 && pre_cnt == 4'h0 && !scaler_clr) ##1
    (!scaler_clr && run && pre_sel == 2'h1) [*3] |-> pre_tick)
    else $error("1:4 prescale tick misplaced");

  // The count advances by one on a tick away from the period.
  count_inc_a: assert property ((pre_tick && !wr_count && !match) |=>
    state_reg.count_register == $past(state_reg.count_register) + 8'h01)
    else $error("count did not increment");

  // The count wraps to zero after a match.
  count_wrap_a: assert property (match |=> state_reg.count_register == 8'h00)
    else $error("count did not wrap on match");

  // A stopped timer keeps its count.
  run_stop_a: assert property ((!run && !wr_count) |=> $stable(state_reg.count_register))
    else $error("count moved while stopped");

  // A control write keeps the count but clears both scalers.
  ctrl_keep_a: assert property (wr_ctrl |=> $stable(state_reg.count_register) && pre_cnt == 4'h0
    && post_cnt == 4'h0)
    else $error("control write disturbed count or scalers");

  // A count write loads the data and clears the scalers.
  count_write_a: assert property (wr_count |=> state_reg.count_register == $past(wbyte)
    && pre_cnt == 4'h0 && post_cnt == 4'h0)
    else $error("count write failed");

  // The postscaler ticks on the match that reaches the selected ratio.
  post_ratio_a: assert property ((match && post_cnt == post_sel) |-> post_tick)
    else $error("postscaler ratio wrong");

  // The flag is set after a postscaler tick and raises the interrupt when unmasked.
  // The interrupt follows the mask that stood in the cycle of the tick, since a mask write may land with it.
  flag_set_a: assert property (post_tick |=> state_reg.flag[pmt_pkg::FLAG_BIT]
    ##0 (!$past(state_reg.mask[pmt_pkg::FLAG_BIT]) || irq))
    else $error("match flag or interrupt not set");

  // The flag stays set until software writes a one to it.
  flag_hold_a: assert property ((state_reg.flag[pmt_pkg::FLAG_BIT]
    && !(finish && pwrite && hit_flag && wbyte[pmt_pkg::FLAG_BIT])) |=> state_reg.flag[pmt_pkg::FLAG_BIT])
    else $error("match flag lost without a clear");

  // The match outputs follow the match event one cycle later.
  match_out_a: assert property (match |=> pwm_time_base && ssp_shift_source)
    else $error("match not forwarded");

  // The serial port source is the match before the postscaler.
  ssp_src_a: assert property (ssp_shift_source == $past(match))
    else $error("serial port source differs from match");

  // A stopped timer holds its prescaler count instead of clearing it.
  pre_hold_a: assert property ((!run && !scaler_clr) |=> $stable(pre_cnt))
    else $error("prescaler moved while stopped");

  // The period register changes only by a bus write.
  period_keep_a: assert property (!(finish && pwrite && hit_period) |=> $stable(state_reg.period_register))
    else $error("period register changed without a write");

  // Main scenarios.
  match_cov_c: cover property (match ##[1:40] match);
  flag_cov_c: cover property (post_tick && post_sel == 4'hF);
  clear_race_c: cover property (post_tick && finish && pwrite && hit_flag);
  err_cov_c: cover property (pready && pslverr);
  pre16_cov_c: cover property (pre_tick && pre_sel == 2'h3);

endmodule : pmt_timer

// file: tb/pmt_timer_bench.sv
// Self-checking testbench of the period match timer.
module pmt_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals, clock and design instance
  // ****************************************************************
  localparam logic [11:0] A_FLAG = {pmt_pkg::IDX_FLAG, 2'b00};
  localparam logic [11:0] A_MASK = {pmt_pkg::IDX_MASK, 2'b00};
  localparam logic [11:0] A_COUNT = {pmt_pkg::IDX_COUNT, 2'b00};
  localparam logic [11:0] A_CTRL = {pmt_pkg::IDX_CTRL, 2'b00};
  localparam logic [11:0] A_PER = {pmt_pkg::IDX_PERIOD, 2'b00};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic pwm_time_base;
  logic ssp_shift_source;
  logic [31:0] rd;
  logic err;
  int error_cnt = 0;
  int n_tests = 0;

  // Clock of 50 MHz.
  always #10 pclk = ~pclk;

  pmt_timer i_pmt_timer (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .irq(irq),
    .pwm_time_base(pwm_time_base),
    .ssp_shift_source(ssp_shift_source)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  // Compares one value and reports a mismatch at once.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Prints the counts and the verdict, then ends the run.
  task stop_test;
    $display("Checks: %0d, mismatches: %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  // One APB transfer; an idle edge follows so that no signal is driven twice in a step.
  // The wait for pready has no cycle limit of its own; the watchdog ends a hang.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Waits for a match pulse, then counts the cycles to the next one.
  task gap(output int c);
    do @(posedge pclk); while (pwm_time_base !== 1'b1);
    c = 0;
    do
    begin
      @(posedge pclk);
      c++;
    end
    while (pwm_time_base !== 1'b1);
  endtask : gap

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Reset values, read-back, unmapped access and a frozen count.
  task t_regs;
    apb(0, A_COUNT, 0);
    chk(rd, 32'h0000_0000);
    apb(0, A_PER, 0);
    chk(rd, 32'h0000_00FF);
    apb(0, A_CTRL, 0);
    chk(rd, 32'h0000_0000);
    apb(0, 12'h004, 0);
    chk({31'h0, err}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    apb(1, A_PER, 32'h0000_005A);
    apb(0, A_PER, 0);
    chk(rd, 32'h0000_005A);
    apb(1, A_COUNT, 32'h0000_00A5);
    apb(1, A_CTRL, 32'h0000_00FB);
    apb(0, A_CTRL, 0);
    chk(rd, 32'h0000_007B);
    repeat (10) @(posedge pclk);
    apb(0, A_COUNT, 0);
    chk(rd, 32'h0000_00A5);
  endtask : t_regs

  // Period match, wrap, both match outputs, flag, mask and clear.
  task t_match;
    int c;
    apb(1, A_PER, 32'h0000_0002);
    apb(1, A_COUNT, 0);
    apb(1, A_MASK, 32'h0000_0002);
    apb(1, A_CTRL, 32'h0000_0004);
    gap(c);
    chk(c, 3);
    chk({31'h0, ssp_shift_source}, 32'h0000_0001);
    apb(0, A_COUNT, 0);
    chk({31'h0, rd <= 32'h2}, 32'h0000_0001);
    apb(1, A_CTRL, 0);
    apb(0, A_FLAG, 0);
    chk(rd & 32'h2, 32'h0000_0002);
    chk({31'h0, irq}, 32'h0000_0001);
    apb(1, A_MASK, 0);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0000);
    apb(1, A_MASK, 32'h0000_0002);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0001);
    apb(1, A_FLAG, 32'h0000_0002);
    repeat (2) @(posedge pclk);
    apb(0, A_FLAG, 0);
    chk(rd & 32'h2, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
  endtask : t_match

  // Every prescale code against the match interval.
  task t_pre;
    int c;
    int r;
    for (int s = 0; s < 4; s++)
    begin
      r = (s == 0) ? 1 : ((s == 1) ? 4 : 16);
      apb(1, A_CTRL, 32'h4 | s);
      gap(c);
      chk(c, 3 * r);
    end
  endtask : t_pre

  // Postscale ratios, with a partly filled postscaler cleared by a count write.
  task t_post;
    int n;
    int c;
    int q[$] = '{3, 7, 15};
    apb(1, A_PER, 32'h0000_0001);
    foreach (q[i])
    begin
      apb(1, A_CTRL, 0);
      apb(1, A_FLAG, 32'h0000_0002);
      apb(1, A_CTRL, 32'h4 | (q[i] << 3));
      apb(1, A_COUNT, 0);
      n = 0;
      c = 0;
      do
      begin
        @(posedge pclk);
        if (pwm_time_base === 1'b1)
          n++;
        if (ssp_shift_source === 1'b1)
          c++;
      end
      while (irq !== 1'b1);
      chk(n, q[i] + 1);
      chk(c, q[i] + 1);
    end
  endtask : t_post

  // Reset in mid-run restores count and period.
  task t_rerun;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, A_COUNT, 0);
    chk(rd, 32'h0000_0000);
    apb(0, A_PER, 0);
    chk(rd, 32'h0000_00FF);
  endtask : t_rerun

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  // Reset, then the scenarios in turn.
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_match();
    t_pre();
    t_post();
    t_rerun();
    stop_test();
  end

  // Cuts a hang short well beyond the expected few hundred cycles.
  initial
  begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    stop_test();
  end

endmodule : pmt_timer_bench
